// File: verilog/aluc_pkg.sv
package aluc_pkg;

   // ----------------------------------------------------------------------
   // Operation and source encodings.
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      ALUC_OP_ADD,
      ALUC_OP_ADD_WITH_CARRY,
      ALUC_OP_SUBTRACT_WITH_BORROW,
      ALUC_OP_AND,
      ALUC_OP_OR,
      ALUC_OP_XOR,
      ALUC_OP_MULTIPLY_ACC_B,
      ALUC_OP_DIVIDE_ACC_B
   } aluc_op_t;

   typedef enum logic [2:0] {
      ALUC_SRC_BANK_REG,
      ALUC_SRC_DIRECT,
      ALUC_SRC_INDIRECT,
      ALUC_SRC_IMMEDIATE,
      ALUC_SRC_DIRECT_DEST_ACC,
      ALUC_SRC_DIRECT_DEST_IMM
   } aluc_src_t;

   // ----------------------------------------------------------------------
   // Instruction lengths in bytes and durations in clock cycles.
   // ----------------------------------------------------------------------
   localparam logic [1:0] ALUC_LEN_ONE = 2'h1;
   localparam logic [1:0] ALUC_LEN_TWO = 2'h2;
   localparam logic [1:0] ALUC_LEN_THREE = 2'h3;
   localparam logic [3:0] ALUC_CYC_ONE = 4'h1;
   localparam logic [3:0] ALUC_CYC_TWO = 4'h2;
   localparam logic [3:0] ALUC_CYC_THREE = 4'h3;
   localparam logic [3:0] ALUC_CYC_MUL = 4'h4;
   localparam logic [3:0] ALUC_CYC_DIV = 4'h8;

   // ----------------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------------
   localparam logic [7:0] ALUC_ACC_RESET = 8'h00;
   localparam logic [7:0] ALUC_B_RESET = 8'h00;

endpackage : aluc_pkg

// File: verilog/aluc_timing.sv
`timescale 1ns/1ps
`default_nettype none

// Combinational length and cycle-count lookup for one instruction form.
module aluc_timing (
   input wire aluc_pkg::aluc_op_t op_in,
   input wire aluc_pkg::aluc_src_t src_in,
   output logic [1:0] len_out,
   output logic [3:0] cycles_out
);

   // ----------------------------------------------------------------------
   // Lookup table.
   // ----------------------------------------------------------------------
   // Multiply and divide ignore the source field; every other form is set by it.
   always_comb begin
      len_out = aluc_pkg::ALUC_LEN_ONE;
      cycles_out = aluc_pkg::ALUC_CYC_ONE;
      if (op_in == aluc_pkg::ALUC_OP_MULTIPLY_ACC_B) begin
         cycles_out = aluc_pkg::ALUC_CYC_MUL;
      end else if (op_in == aluc_pkg::ALUC_OP_DIVIDE_ACC_B) begin
         cycles_out = aluc_pkg::ALUC_CYC_DIV;
      end else begin
         unique case (src_in)
            aluc_pkg::ALUC_SRC_BANK_REG: begin
               len_out = aluc_pkg::ALUC_LEN_ONE;
               cycles_out = aluc_pkg::ALUC_CYC_ONE;
            end
            aluc_pkg::ALUC_SRC_DIRECT: begin
               len_out = aluc_pkg::ALUC_LEN_TWO;
               cycles_out = aluc_pkg::ALUC_CYC_TWO;
            end
            aluc_pkg::ALUC_SRC_INDIRECT: begin
               len_out = aluc_pkg::ALUC_LEN_ONE;
               cycles_out = aluc_pkg::ALUC_CYC_TWO;
            end
            aluc_pkg::ALUC_SRC_IMMEDIATE: begin
               len_out = aluc_pkg::ALUC_LEN_TWO;
               cycles_out = aluc_pkg::ALUC_CYC_TWO;
            end
            aluc_pkg::ALUC_SRC_DIRECT_DEST_ACC: begin
               len_out = aluc_pkg::ALUC_LEN_TWO;
               cycles_out = aluc_pkg::ALUC_CYC_TWO;
            end
            aluc_pkg::ALUC_SRC_DIRECT_DEST_IMM: begin
               len_out = aluc_pkg::ALUC_LEN_THREE;
               cycles_out = aluc_pkg::ALUC_CYC_THREE;
            end
            default: begin
               len_out = aluc_pkg::ALUC_LEN_ONE;
               cycles_out = aluc_pkg::ALUC_CYC_ONE;
            end
         endcase
      end
   end

endmodule : aluc_timing

`default_nettype wire

// File: verilog/aluc_core.sv
`timescale 1ns/1ps
`default_nettype none

module aluc_core (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire aluc_pkg::aluc_op_t op_in,
   input wire aluc_pkg::aluc_src_t src_in,
   input wire logic [7:0] operand_in,
   input wire logic [7:0] acc_load_in,
   input wire logic acc_load_en_in,
   input wire logic [7:0] b_load_in,
   input wire logic b_load_en_in,
   input wire logic carry_load_in,
   input wire logic carry_load_en_in,
   output logic busy_out,
   output logic done_out,
   output logic [1:0] len_out,
   output logic [7:0] acc_out,
   output logic [7:0] b_out,
   output logic carry_out,
   output logic aux_carry_out,
   output logic overflow_out,
   output logic [7:0] mem_wdata_out,
   output logic mem_we_out
);

   typedef enum logic [1:0] {
      ALUC_IDLE,
      ALUC_RUN
   } aluc_state_t;

   // ----------------------------------------------------------------------
   // Arithmetic helpers.
   // ----------------------------------------------------------------------
   // Nine-bit add of a, b and carry-in; bit 8 is the carry out.
   function automatic logic [8:0] aluc_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic ci);
      aluc_add = {1'b0, a} + {1'b0, b} + {8'h00, ci};
   endfunction : aluc_add

   // Nibble add for the auxiliary carry.
   function automatic logic [4:0] aluc_nib(input logic [3:0] a, input logic [3:0] b,
                                           input logic ci);
      aluc_nib = {1'b0, a} + {1'b0, b} + {4'h0, ci};
   endfunction : aluc_nib

   aluc_state_t state_r, state_nxt;
   logic [3:0] count_r, count_nxt;
   aluc_pkg::aluc_op_t op_r, op_nxt;
   aluc_pkg::aluc_src_t src_r, src_nxt;
   logic [7:0] opd_r, opd_nxt;
   logic [7:0] acc_r, acc_nxt;
   logic [7:0] b_r, b_nxt;
   logic cy_r, cy_nxt;
   logic ac_r, ac_nxt;
   logic ov_r, ov_nxt;
   logic done_r, done_nxt;
   logic [1:0] len_r, len_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic we_r, we_nxt;
   logic busy_r, busy_nxt;
   logic [1:0] tab_len;
   logic [3:0] tab_cycles;

   // ----------------------------------------------------------------------
   // Timing lookup.
   // ----------------------------------------------------------------------
   aluc_timing u_timing (
      .op_in(op_in),
      .src_in(src_in),
      .len_out(tab_len),
      .cycles_out(tab_cycles)
   );

   // ----------------------------------------------------------------------
   // Sequencer and datapath.
   // ----------------------------------------------------------------------
   // The counter is loaded with the full cycle total, fetch included, and the
   // result commits on the last cycle so done marks the end exactly.
   always_comb begin
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] inv;
      logic [15:0] prod;
      logic [7:0] res;
      logic lastc;
      sum = 9'h000;
      nib = 5'h00;
      inv = 8'h00;
      prod = 16'h0000;
      res = 8'h00;
      lastc = 1'b0;
      state_nxt = state_r;
      count_nxt = count_r;
      op_nxt = op_r;
      src_nxt = src_r;
      opd_nxt = opd_r;
      acc_nxt = acc_r;
      b_nxt = b_r;
      cy_nxt = cy_r;
      ac_nxt = ac_r;
      ov_nxt = ov_r;
      done_nxt = 1'b0;
      len_nxt = len_r;
      wdata_nxt = wdata_r;
      we_nxt = 1'b0;
      if (state_r == ALUC_IDLE) begin
         if (acc_load_en_in) begin
            acc_nxt = acc_load_in;
         end
         if (b_load_en_in) begin
            b_nxt = b_load_in;
         end
         if (carry_load_en_in) begin
            cy_nxt = carry_load_in;
         end
      end
      unique case (state_r)
         ALUC_IDLE: begin
            if (start_in) begin
               op_nxt = op_in;
               src_nxt = src_in;
               opd_nxt = operand_in;
               len_nxt = tab_len;
               count_nxt = tab_cycles;
               state_nxt = ALUC_RUN;
            end
         end
         ALUC_RUN: begin
            count_nxt = count_r - 4'h1;
            lastc = (count_r == 4'h1);
         end
         default: begin
            state_nxt = ALUC_IDLE;
         end
      endcase
      if (lastc) begin
         state_nxt = ALUC_IDLE;
         done_nxt = 1'b1;
         unique case (op_r)
            aluc_pkg::ALUC_OP_ADD, aluc_pkg::ALUC_OP_ADD_WITH_CARRY: begin
               sum = aluc_add(acc_r, opd_r,
                              (op_r == aluc_pkg::ALUC_OP_ADD_WITH_CARRY) & cy_r);
               nib = aluc_nib(acc_r[3:0], opd_r[3:0],
                              (op_r == aluc_pkg::ALUC_OP_ADD_WITH_CARRY) & cy_r);
               acc_nxt = sum[7:0];
               cy_nxt = sum[8];
               ac_nxt = nib[4];
               ov_nxt = (acc_r[7] == opd_r[7]) && (sum[7] != acc_r[7]);
            end
            aluc_pkg::ALUC_OP_SUBTRACT_WITH_BORROW: begin
               // Subtract as add of the inverse; the borrow is the inverted carry.
               inv = ~opd_r;
               sum = aluc_add(acc_r, inv, ~cy_r);
               nib = aluc_nib(acc_r[3:0], inv[3:0], ~cy_r);
               acc_nxt = sum[7:0];
               cy_nxt = ~sum[8];
               ac_nxt = ~nib[4];
               ov_nxt = (acc_r[7] != opd_r[7]) && (sum[7] != acc_r[7]);
            end
            aluc_pkg::ALUC_OP_AND, aluc_pkg::ALUC_OP_OR, aluc_pkg::ALUC_OP_XOR: begin
               if (op_r == aluc_pkg::ALUC_OP_AND) begin
                  res = acc_r & opd_r;
               end else if (op_r == aluc_pkg::ALUC_OP_OR) begin
                  res = acc_r | opd_r;
               end else begin
                  res = acc_r ^ opd_r;
               end
               // Direct-destination forms write memory, leaving the accumulator.
               if (src_r == aluc_pkg::ALUC_SRC_DIRECT_DEST_ACC ||
                   src_r == aluc_pkg::ALUC_SRC_DIRECT_DEST_IMM) begin
                  wdata_nxt = res;
                  we_nxt = 1'b1;
               end else begin
                  acc_nxt = res;
               end
            end
            aluc_pkg::ALUC_OP_MULTIPLY_ACC_B: begin
               prod = {8'h00, acc_r} * {8'h00, b_r};
               acc_nxt = prod[7:0];
               b_nxt = prod[15:8];
               cy_nxt = 1'b0;
               ov_nxt = (prod[15:8] != 8'h00);
            end
            aluc_pkg::ALUC_OP_DIVIDE_ACC_B: begin
               // Divide by zero leaves both operands untouched and flags overflow.
               cy_nxt = 1'b0;
               if (b_r == 8'h00) begin
                  ov_nxt = 1'b1;
               end else begin
                  acc_nxt = acc_r / b_r;
                  b_nxt = acc_r % b_r;
                  ov_nxt = 1'b0;
               end
            end
            default: begin
               done_nxt = 1'b1;
            end
         endcase
      end
      // Busy is registered from the next state so the port needs no decode.
      busy_nxt = (state_nxt == ALUC_RUN);
   end

   // Register stage for the sequencer and datapath.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= ALUC_IDLE;
         count_r <= 4'h0;
         op_r <= aluc_pkg::ALUC_OP_ADD;
         src_r <= aluc_pkg::ALUC_SRC_BANK_REG;
         opd_r <= 8'h00;
         acc_r <= aluc_pkg::ALUC_ACC_RESET;
         b_r <= aluc_pkg::ALUC_B_RESET;
         cy_r <= 1'b0;
         ac_r <= 1'b0;
         ov_r <= 1'b0;
         done_r <= 1'b0;
         len_r <= 2'h0;
         wdata_r <= 8'h00;
         we_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         op_r <= op_nxt;
         src_r <= src_nxt;
         opd_r <= opd_nxt;
         acc_r <= acc_nxt;
         b_r <= b_nxt;
         cy_r <= cy_nxt;
         ac_r <= ac_nxt;
         ov_r <= ov_nxt;
         done_r <= done_nxt;
         len_r <= len_nxt;
         wdata_r <= wdata_nxt;
         we_r <= we_nxt;
         busy_r <= busy_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, all straight from flip-flops.
   // ----------------------------------------------------------------------
   assign busy_out = busy_r;
   assign done_out = done_r;
   assign len_out = len_r;
   assign acc_out = acc_r;
   assign b_out = b_r;
   assign carry_out = cy_r;
   assign aux_carry_out = ac_r;
   assign overflow_out = ov_r;
   assign mem_wdata_out = wdata_r;
   assign mem_we_out = we_r;

endmodule : aluc_core

`default_nettype wire

// File: verif/aluc_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Port timing checks for the core.
// ----------------------------------------------------------------------
module aluc_checker (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire aluc_pkg::aluc_op_t op_in,
   input wire aluc_pkg::aluc_src_t src_in,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic [1:0] len_out,
   input wire logic mem_we_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // A start is taken only in idle; multiply and divide ignore the form.
   wire take = start_in && !busy_out;
   wire alu = !(op_in inside {aluc_pkg::ALUC_OP_MULTIPLY_ACC_B, aluc_pkg::ALUC_OP_DIVIDE_ACC_B});
   wire lgc = op_in inside {aluc_pkg::ALUC_OP_AND, aluc_pkg::ALUC_OP_OR};
   a_reg_one_cycle: assert property (take && alu && src_in == aluc_pkg::ALUC_SRC_BANK_REG
      |=> busy_out ##1 done_out && !busy_out && len_out == 2'h1) else $error("register form");
   a_direct_two_cycle: assert property (take && alu && src_in == aluc_pkg::ALUC_SRC_DIRECT
      |=> busy_out[*2] ##1 done_out && len_out == 2'h2) else $error("direct form");
   a_indirect_two_cycle: assert property (take && alu && src_in == aluc_pkg::ALUC_SRC_INDIRECT
      |=> busy_out[*2] ##1 done_out && len_out == 2'h1) else $error("indirect form");
   a_immediate_two_cycle: assert property (take && alu && src_in == aluc_pkg::ALUC_SRC_IMMEDIATE
      |=> busy_out[*2] ##1 done_out && len_out == 2'h2) else $error("immediate form");
   a_dest_acc_two: assert property (take && lgc && src_in == aluc_pkg::ALUC_SRC_DIRECT_DEST_ACC
      |=> busy_out[*2] ##1 done_out && mem_we_out && len_out == 2'h2) else $error("dest acc form");
   a_dest_imm_three: assert property (take && lgc && src_in == aluc_pkg::ALUC_SRC_DIRECT_DEST_IMM
      |=> busy_out[*3] ##1 done_out && mem_we_out && len_out == 2'h3) else $error("dest imm form");
   a_mul_four_cycle: assert property (take && op_in == aluc_pkg::ALUC_OP_MULTIPLY_ACC_B
      |=> busy_out[*4] ##1 done_out && !busy_out && len_out == 2'h1) else $error("multiply timing");
   a_div_eight_cycle: assert property (take && op_in == aluc_pkg::ALUC_OP_DIVIDE_ACC_B
      |=> busy_out[*8] ##1 done_out && !busy_out && len_out == 2'h1) else $error("divide timing");
   a_mem_we_done: assert property (mem_we_out |-> done_out) else $error("stray write");
   a_done_after_busy: assert property (done_out |-> $past(busy_out)) else $error("early done");
endmodule : aluc_checker

bind aluc_core aluc_checker aluc_checker_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .start_in(start_in), .op_in(op_in), .src_in(src_in), .busy_out(busy_out),
   .done_out(done_out), .len_out(len_out), .mem_we_out(mem_we_out));
`default_nettype wire

// File: verif/test_cpu_alu_instruction_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_alu_instruction_timing;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic start_in = 1'b0;
   aluc_pkg::aluc_op_t op_in = aluc_pkg::ALUC_OP_ADD;
   aluc_pkg::aluc_src_t src_in = aluc_pkg::ALUC_SRC_BANK_REG;
   logic [7:0] operand_in = 8'h00;
   logic [7:0] acc_load_in = 8'h00;
   logic [7:0] b_load_in = 8'h00;
   logic acc_load_en_in = 1'b0;
   logic b_load_en_in = 1'b0;
   logic carry_load_in = 1'b0;
   logic carry_load_en_in = 1'b0;
   logic busy_out, done_out, carry_out, aux_carry_out, overflow_out, mem_we_out;
   logic [1:0] len_out;
   logic [7:0] acc_out, b_out, mem_wdata_out;
   logic [7:0] acc_m, b_m;
   logic c_m, ac_m, ov_m;
   int errors = 0;
   int comparisons = 0;

   aluc_core aluc_core_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .start_in(start_in),
      .op_in(op_in), .src_in(src_in), .operand_in(operand_in), .acc_load_in(acc_load_in),
      .acc_load_en_in(acc_load_en_in), .b_load_in(b_load_in), .b_load_en_in(b_load_en_in),
      .carry_load_in(carry_load_in), .carry_load_en_in(carry_load_en_in),
      .busy_out(busy_out), .done_out(done_out), .len_out(len_out), .acc_out(acc_out),
      .b_out(b_out), .carry_out(carry_out), .aux_carry_out(aux_carry_out),
      .overflow_out(overflow_out), .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out));

   // 50 MHz clock.
   initial begin
      forever #10 mclk_in = ~mclk_in;
   end

   // ----------------------------------------------------------------------
   // Reporting.
   // ----------------------------------------------------------------------
   task stop_test;
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // ----------------------------------------------------------------------
   // Expected results, lengths and cycle counts from the bench's own state.
   // ----------------------------------------------------------------------
   function void predict(input aluc_pkg::aluc_op_t op, input aluc_pkg::aluc_src_t src,
      input logic [7:0] x, output logic [7:0] a, output logic [7:0] b, output logic c,
      output logic [7:0] w, output logic [1:0] l, output logic [3:0] n,
      output logic ac, output logic ov);
      logic [7:0] s;
      logic ci;
      logic [4:0] h;
      a = acc_m;
      b = b_m;
      c = c_m;
      ac = ac_m;
      ov = ov_m;
      ci = (op == aluc_pkg::ALUC_OP_ADD_WITH_CARRY) & c_m;
      w = 8'h00;
      l = (src inside {aluc_pkg::ALUC_SRC_DIRECT, aluc_pkg::ALUC_SRC_IMMEDIATE,
         aluc_pkg::ALUC_SRC_DIRECT_DEST_ACC}) ? 2'h2 :
         (src == aluc_pkg::ALUC_SRC_DIRECT_DEST_IMM) ? 2'h3 : 2'h1;
      n = (src == aluc_pkg::ALUC_SRC_BANK_REG) ? 4'h1 :
         (src == aluc_pkg::ALUC_SRC_DIRECT_DEST_IMM) ? 4'h3 : 4'h2;
      s = (op == aluc_pkg::ALUC_OP_AND) ? (acc_m & x) :
         (op == aluc_pkg::ALUC_OP_OR) ? (acc_m | x) : (acc_m ^ x);
      case (op)
         aluc_pkg::ALUC_OP_ADD, aluc_pkg::ALUC_OP_ADD_WITH_CARRY: begin
            {c, a} = {1'b0, acc_m} + {1'b0, x} + {8'h00, ci};
            h = {1'b0, acc_m[3:0]} + {1'b0, x[3:0]} + {4'h0, ci};
            ac = h[4];
            ov = (acc_m[7] == x[7]) && (a[7] != acc_m[7]);
         end
         aluc_pkg::ALUC_OP_SUBTRACT_WITH_BORROW: begin
            // Borrows fall out of the wrap of the extra top bit.
            {c, a} = {1'b0, acc_m} - {1'b0, x} - {8'h00, c_m};
            h = {1'b0, acc_m[3:0]} - {1'b0, x[3:0]} - {4'h0, c_m};
            ac = h[4];
            ov = (acc_m[7] != x[7]) && (a[7] != acc_m[7]);
         end
         aluc_pkg::ALUC_OP_MULTIPLY_ACC_B: begin
            {b, a} = {8'h00, acc_m} * {8'h00, b_m};
            c = 1'b0;
            ov = (b != 8'h00);
            l = 2'h1;
            n = 4'h4;
         end
         aluc_pkg::ALUC_OP_DIVIDE_ACC_B: begin
            c = 1'b0;
            l = 2'h1;
            n = 4'h8;
            ov = (b_m == 8'h00);
            if (b_m != 8'h00) begin
               a = acc_m / b_m;
               b = acc_m % b_m;
            end
         end
         default: if (src < aluc_pkg::ALUC_SRC_DIRECT_DEST_ACC) a = s; else w = s;
      endcase
   endfunction : predict

   // ----------------------------------------------------------------------
   // Drivers, called at a falling edge while the core is idle or done.
   // ----------------------------------------------------------------------
   task load(input logic [7:0] a, input logic [7:0] b, input logic c);
      {acc_load_in, b_load_in, carry_load_in} = {a, b, c};
      {acc_load_en_in, b_load_en_in, carry_load_en_in} = 3'h7;
      @(negedge mclk_in);
      {acc_load_en_in, b_load_en_in, carry_load_en_in} = 3'h0;
      {acc_m, b_m, c_m} = {a, b, c};
   endtask : load

   task run(input aluc_pkg::aluc_op_t op, input aluc_pkg::aluc_src_t src, input logic [7:0] x);
      logic [7:0] ea, eb, ew;
      logic ec, m, eac, eov;
      logic [1:0] el;
      logic [3:0] en;
      int k;
      predict(op, src, x, ea, eb, ec, ew, el, en, eac, eov);
      m = !(op inside {aluc_pkg::ALUC_OP_MULTIPLY_ACC_B, aluc_pkg::ALUC_OP_DIVIDE_ACC_B}) &&
         src >= aluc_pkg::ALUC_SRC_DIRECT_DEST_ACC;
      start_in = 1'b1;
      op_in = op;
      src_in = src;
      operand_in = x;
      @(negedge mclk_in);
      // A second start and an accumulator load while busy must both be ignored.
      start_in = (en > 4'h1);
      op_in = aluc_pkg::aluc_op_t'($urandom_range(7));
      acc_load_en_in = (en > 4'h1);
      acc_load_in = 8'($urandom);
      k = 0;
      while (done_out !== 1'b1 && k < 12) begin
         @(negedge mclk_in);
         start_in = 1'b0;
         acc_load_en_in = 1'b0;
         k++;
      end
      if (k >= 12) begin
         errors++;
         stop_test();
      end
      check(8'(k), 8'(en));
      check(8'(len_out), 8'(el));
      check(acc_out, ea);
      check(b_out, eb);
      check(8'(carry_out), 8'(ec));
      check(8'(mem_we_out), 8'(m));
      if (m) check(mem_wdata_out, ew);
      check(8'(overflow_out), 8'(eov));
      check(8'(aux_carry_out), 8'(eac));
      {acc_m, b_m, c_m, ac_m, ov_m} = {ea, eb, ec, eac, eov};
   endtask : run

   // ----------------------------------------------------------------------
   // Main sequence: corners, a full sweep, random traffic, a mid-run reset.
   // ----------------------------------------------------------------------
   initial begin
      int o, s;
      void'($urandom(55606));
      repeat (12) @(negedge mclk_in);
      rst_n_in = 1'b1;
      {acc_m, b_m, c_m, ac_m, ov_m} = 19'h0;
      check(acc_out, 8'h00);
      check(b_out, 8'h00);
      load(8'hff, 8'h00, 1'b1);
      run(aluc_pkg::ALUC_OP_ADD_WITH_CARRY, aluc_pkg::ALUC_SRC_BANK_REG, 8'hff);
      load(8'h00, 8'h00, 1'b1);
      run(aluc_pkg::ALUC_OP_SUBTRACT_WITH_BORROW, aluc_pkg::ALUC_SRC_IMMEDIATE, 8'h00);
      run(aluc_pkg::ALUC_OP_DIVIDE_ACC_B, aluc_pkg::ALUC_SRC_BANK_REG, 8'h00);
      load(8'hff, 8'hff, 1'b0);
      run(aluc_pkg::ALUC_OP_MULTIPLY_ACC_B, aluc_pkg::ALUC_SRC_DIRECT, 8'h00);
      // Every operation in the first four forms, and AND, OR and XOR in all six, back to back with random operands.
      for (o = 0; o < 8; o++) begin
         for (s = 0; s < 6; s++) begin
            if (s < 4 || (o >= 3 && o <= 5))
               run(aluc_pkg::aluc_op_t'(o), aluc_pkg::aluc_src_t'(s), 8'($urandom));
         end
      end
      repeat (150) begin
         o = $urandom_range(7);
         s = (o >= 3 && o <= 5) ? $urandom_range(5) : $urandom_range(3);
         if ($urandom_range(1) == 0) load(8'($urandom), 8'($urandom), 1'($urandom));
         run(aluc_pkg::aluc_op_t'(o), aluc_pkg::aluc_src_t'(s), 8'($urandom));
      end
      // Reset in mid-divide returns the core to idle with cleared registers.
      start_in = 1'b1;
      op_in = aluc_pkg::ALUC_OP_DIVIDE_ACC_B;
      @(negedge mclk_in);
      start_in = 1'b0;
      @(negedge mclk_in);
      rst_n_in = 1'b0;
      @(negedge mclk_in);
      rst_n_in = 1'b1;
      check(8'(busy_out), 8'h00);
      check(acc_out, 8'h00);
      check(b_out, 8'h00);
      {acc_m, b_m, c_m, ac_m, ov_m} = 19'h0;
      run(aluc_pkg::ALUC_OP_ADD, aluc_pkg::ALUC_SRC_INDIRECT, 8'h5a);
      stop_test();
   end
endmodule : test_cpu_alu_instruction_timing
`default_nettype wire
